// ### verilog/sub_sleep_pkg.sv
// Constants shared by the subtract/sleep execution block and its subtractor.
// Assumes a 32-bit AHB-Lite register bus and a 4096-byte data space.
package sub_sleep_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_INSTR    = 8'h00;
  localparam logic [7:0] OFS_WORKING  = 8'h04;
  localparam logic [7:0] OFS_STATUS   = 8'h08;
  localparam logic [7:0] OFS_BANKSEL  = 8'h0C;
  localparam logic [7:0] OFS_CTRL     = 8'h10;
  localparam logic [7:0] OFS_POWER    = 8'h14;
  localparam logic [7:0] OFS_WATCHDOG = 8'h18;
  localparam logic [7:0] OFS_IDXBASE  = 8'h1C;
  localparam logic [7:0] OFS_MEMADDR  = 8'h20;
  localparam logic [7:0] OFS_MEMDATA  = 8'h24;
  // Status field positions
  localparam int ST_CARRY    = 0;
  localparam int ST_DIGIT    = 1;
  localparam int ST_ZERO     = 2;
  localparam int ST_OVERFLOW = 3;
  localparam int ST_NEGATIVE = 4;
  // Control field positions
  localparam int CTRL_EXT_EN = 0;
  localparam int CTRL_WAKE   = 1;
  // Power field positions
  localparam int PWR_POWER_DOWN = 0;
  localparam int PWR_TIME_OUT   = 1;
  localparam int PWR_ASLEEP     = 2;
  // Reset values
  localparam logic [4:0]  STATUS_RST  = 5'h00;
  localparam logic [3:0]  BANK_RST    = 4'h0;
  localparam logic [11:0] IDXBASE_RST = 12'h000;
  // Opcodes
  localparam logic [15:0] OP_SLEEP       = 16'h0003;
  localparam logic [7:0]  OP_LIT_SUB     = 8'h08;
  localparam logic [5:0]  OP_FILE_SUB    = 6'b010111;
  localparam logic [5:0]  OP_FILE_SUBB   = 6'b010110;
  localparam logic [5:0]  OP_WORK_SUBB   = 6'b010101;
  // Access bank split and fixed banks
  localparam logic [7:0]  ACCESS_SPLIT   = 8'h60;
  localparam logic [7:0]  INDEXED_LIMIT  = 8'h5F;
  localparam logic [3:0]  ACCESS_LO_BANK = 4'h0;
  localparam logic [3:0]  ACCESS_HI_BANK = 4'hF;
  localparam int          MEM_BYTES      = 4096;
endpackage

// ### verilog/sub_alu_if.sv
// Operand and result bundle between the execution block and its subtractor.
// Assumes one user and one purely combinational subtractor.
`timescale 1ns/1ps
`default_nettype none
interface sub_alu_if;
  logic [7:0] minuend;    // Left operand
  logic [7:0] subtrahend; // Right operand
  logic       carryIn;    // One means no borrow pending
  logic [7:0] result;     // Difference
  logic [4:0] flags;      // N, OV, Z, DC, C
  modport alu  (input minuend, subtrahend, carryIn, output result, flags);
  modport user (output minuend, subtrahend, carryIn, input result, flags);
endinterface
`default_nettype wire

// ### verilog/sub_alu.sv
// Eight-bit two's complement subtractor with borrow and status flags.
// Assumes the caller registers the outputs; purely combinational.
`timescale 1ns/1ps
`default_nettype none
module sub_alu (
  sub_alu_if.alu port
);
  logic [8:0] sum;   // Full sum with carry out
  logic [4:0] low;   // Low nibble sum with digit carry
  logic [7:0] inv;   // Inverted subtrahend

  // Subtraction as addition of the complement; carry one means no borrow
  always_comb begin
    inv = ~port.subtrahend;
    sum = {1'b0, port.minuend} + {1'b0, inv} + {8'h00, port.carryIn};
    low = {1'b0, port.minuend[3:0]} + {1'b0, inv[3:0]} + {4'h0, port.carryIn};
    port.result = sum[7:0];
    port.flags[sub_sleep_pkg::ST_CARRY] = sum[8];
    port.flags[sub_sleep_pkg::ST_DIGIT] = low[4];
    port.flags[sub_sleep_pkg::ST_ZERO] = (sum[7:0] == 8'h00);
    port.flags[sub_sleep_pkg::ST_OVERFLOW] = (port.minuend[7] != port.subtrahend[7]) &&
                                            (sum[7] != port.minuend[7]);
    port.flags[sub_sleep_pkg::ST_NEGATIVE] = sum[7];
  end
endmodule
`default_nettype wire

// ### verilog/sub_sleep_core.sv
// Subtract and low-power instruction execution unit behind an AHB-Lite slave.
// Assumes one master; an instruction runs when software writes the instruction word while awake.
`timescale 1ns/1ps
`default_nettype none
module sub_sleep_core (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  output logic             oscStopped
);
  sub_alu_if alu ();                  // Subtractor bundle
  sub_alu u_alu (.port(alu));

  logic        rstSync1_reg;          // Reset synchroniser, first stage
  logic        rstSync2_reg;          // Released reset for the block
  logic        dpWrite_reg;           // Write data phase pending
  logic        dpWrite_next;
  logic        rdWait_reg;            // Read data phase wait state
  logic        rdWait_next;
  logic [7:0]  dpAddr_reg;            // Latched register offset
  logic [7:0]  dpAddr_next;
  logic [31:0] hrdata_reg;            // Read data
  logic [31:0] hrdata_next;
  logic [7:0]  wReg_reg;              // Working register
  logic [7:0]  wReg_next;
  logic [4:0]  status_reg;            // Arithmetic flags
  logic [4:0]  status_next;
  logic [3:0]  bank_reg;              // bank_select_register
  logic [3:0]  bank_next;
  logic        extEn_reg;             // Extended set enabled
  logic        extEn_next;
  logic        asleep_reg;            // Low-power state
  logic        asleep_next;
  logic        timeOutFlag_reg;       // time_out_flag
  logic        timeOutFlag_next;
  logic        powerDownFlag_reg;     // power_down_flag
  logic        powerDownFlag_next;
  logic [7:0]  watchdogCounter_reg;   // watchdog_counter
  logic [7:0]  watchdogCounter_next;
  logic [7:0]  postscaler_reg;        // Watchdog postscaler
  logic [7:0]  postscaler_next;
  logic [11:0] idxBase_reg;           // Indexed offset base
  logic [11:0] idxBase_next;
  logic [11:0] memAddr_reg;           // Software memory pointer
  logic [11:0] memAddr_next;
  logic [15:0] lastInstr_reg;         // Last instruction written
  logic [15:0] lastInstr_next;
  logic [7:0]  mem [sub_sleep_pkg::MEM_BYTES];  // Data space
  logic        memWe;                 // Data space write enable
  logic [11:0] memWa;                 // Data space write address
  logic [7:0]  memWd;                 // Data space write data
  logic        addrPhase;             // Transfer taken this edge
  logic        instrWr;               // Instruction word written
  logic [15:0] op;                    // Instruction word
  logic [11:0] fileAddr;              // Resolved file address
  logic [7:0]  fileVal;               // File operand
  logic        isSleep;               // Sleep decoded
  logic        isLit;                 // Literal subtract decoded
  logic        isFile;                // Any file subtract decoded
  // Two-stage reset release
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rstSync1_reg <= 1'b0;
      rstSync2_reg <= 1'b0;
    end else begin
      rstSync1_reg <= 1'b1;
      rstSync2_reg <= rstSync1_reg;
    end
  end
  // Bus handshake: writes take no wait, reads one
  assign addrPhase  = hsel && htrans[1] && hready;
  assign hreadyout  = !rdWait_reg;
  assign hresp      = 1'b0;
  assign hrdata     = hrdata_reg;
  assign oscStopped = asleep_reg;
  assign instrWr    = dpWrite_reg && (dpAddr_reg == sub_sleep_pkg::OFS_INSTR) && !asleep_reg;
  assign op         = hwdata[15:0];
  // Decode and operand addressing
  always_comb begin
    isSleep = instrWr && (op == sub_sleep_pkg::OP_SLEEP);
    isLit   = instrWr && (op[15:8] == sub_sleep_pkg::OP_LIT_SUB);
    isFile  = instrWr && ((op[15:10] == sub_sleep_pkg::OP_FILE_SUB) ||
                          (op[15:10] == sub_sleep_pkg::OP_FILE_SUBB) ||
                          (op[15:10] == sub_sleep_pkg::OP_WORK_SUBB));
    if (op[8]) begin
      fileAddr = {bank_reg, op[7:0]};
    end else if (extEn_reg && (op[7:0] <= sub_sleep_pkg::INDEXED_LIMIT)) begin
      fileAddr = 12'(idxBase_reg + {4'h0, op[7:0]});
    end else if (op[7:0] < sub_sleep_pkg::ACCESS_SPLIT) begin
      fileAddr = {sub_sleep_pkg::ACCESS_LO_BANK, op[7:0]};
    end else begin
      fileAddr = {sub_sleep_pkg::ACCESS_HI_BANK, op[7:0]};
    end
    fileVal = mem[fileAddr];
    // Operand steering
    alu.carryIn    = status_reg[sub_sleep_pkg::ST_CARRY];
    alu.minuend    = fileVal;
    alu.subtrahend = wReg_reg;
    if (isLit) begin
      alu.minuend = op[7:0];
      alu.carryIn = 1'b1;
    end else if (op[15:10] == sub_sleep_pkg::OP_FILE_SUB) begin
      alu.carryIn = 1'b1;
    end else if (op[15:10] == sub_sleep_pkg::OP_WORK_SUBB) begin
      alu.minuend    = wReg_reg;
      alu.subtrahend = fileVal;
    end
  end
  // Next state for bus, core and power state
  always_comb begin
    dpWrite_next = addrPhase && hwrite;
    rdWait_next  = addrPhase && !hwrite;
    dpAddr_next  = addrPhase ? haddr[7:0] : dpAddr_reg;
    hrdata_next  = hrdata_reg;
    wReg_next = wReg_reg;
    status_next = status_reg;
    bank_next = bank_reg;
    extEn_next = extEn_reg;
    asleep_next = asleep_reg;
    timeOutFlag_next = timeOutFlag_reg;
    powerDownFlag_next = powerDownFlag_reg;
    idxBase_next = idxBase_reg;
    memAddr_next = memAddr_reg;
    lastInstr_next = lastInstr_reg;
    memWe = 1'b0;
    memWa = memAddr_reg;
    memWd = hwdata[7:0];
    // Watchdog free runs; postscaler counts its wraps
    watchdogCounter_next = watchdogCounter_reg + 8'h01;
    postscaler_next = postscaler_reg + {7'h00, (watchdogCounter_reg == 8'hFF)};
    // Read mux sampled in the wait cycle, after any prior write landed
    if (rdWait_reg) begin
      unique case (dpAddr_reg)
        sub_sleep_pkg::OFS_INSTR:    hrdata_next = {16'h0000, lastInstr_reg};
        sub_sleep_pkg::OFS_WORKING:  hrdata_next = {24'h00_0000, wReg_reg};
        sub_sleep_pkg::OFS_STATUS:   hrdata_next = {27'h000_0000, status_reg};
        sub_sleep_pkg::OFS_BANKSEL:  hrdata_next = {28'h000_0000, bank_reg};
        sub_sleep_pkg::OFS_CTRL:     hrdata_next = {31'h0000_0000, extEn_reg};
        sub_sleep_pkg::OFS_POWER:    hrdata_next = {29'h0000_0000, asleep_reg,
                                                   timeOutFlag_reg, powerDownFlag_reg};
        sub_sleep_pkg::OFS_WATCHDOG: hrdata_next = {16'h0000, postscaler_reg, watchdogCounter_reg};
        sub_sleep_pkg::OFS_IDXBASE:  hrdata_next = {20'h0_0000, idxBase_reg};
        sub_sleep_pkg::OFS_MEMADDR:  hrdata_next = {20'h0_0000, memAddr_reg};
        sub_sleep_pkg::OFS_MEMDATA:  hrdata_next = {24'h00_0000, mem[memAddr_reg]};
        default:                     hrdata_next = 32'h0000_0000;
      endcase
    end
    // Register writes in the data phase
    if (dpWrite_reg) begin
      unique case (dpAddr_reg)
        sub_sleep_pkg::OFS_INSTR:    lastInstr_next = op;
        sub_sleep_pkg::OFS_WORKING:  wReg_next = hwdata[7:0];
        sub_sleep_pkg::OFS_STATUS:   status_next = hwdata[4:0];
        sub_sleep_pkg::OFS_BANKSEL:  bank_next = hwdata[3:0];
        sub_sleep_pkg::OFS_CTRL: begin
          extEn_next = hwdata[sub_sleep_pkg::CTRL_EXT_EN];
          if (hwdata[sub_sleep_pkg::CTRL_WAKE]) begin
            asleep_next = 1'b0;
          end
        end
        sub_sleep_pkg::OFS_IDXBASE:  idxBase_next = hwdata[11:0];
        sub_sleep_pkg::OFS_MEMADDR:  memAddr_next = hwdata[11:0];
        sub_sleep_pkg::OFS_MEMDATA:  memWe = 1'b1;
        default: begin
        end
      endcase
    end
    // Low-power entry
    if (isSleep) begin
      timeOutFlag_next = 1'b1;
      powerDownFlag_next = 1'b0;
      watchdogCounter_next = 8'h00;
      postscaler_next = 8'h00;
      asleep_next = 1'b1;
    end
    // Subtract results and flags land in this one cycle
    if (isLit || isFile) begin
      status_next = alu.flags;
      if (isFile && op[9]) begin
        memWe = 1'b1;
        memWa = fileAddr;
        memWd = alu.result;
      end else begin
        wReg_next = alu.result;
      end
    end
  end
  // State registers
  always_ff @(posedge clk or negedge rstSync2_reg) begin
    if (!rstSync2_reg) begin
      dpWrite_reg <= 1'b0;
      rdWait_reg <= 1'b0;
      dpAddr_reg <= 8'h00;
      hrdata_reg <= 32'h0000_0000;
      wReg_reg <= 8'h00;
      status_reg <= sub_sleep_pkg::STATUS_RST;
      bank_reg <= sub_sleep_pkg::BANK_RST;
      extEn_reg <= 1'b0;
      asleep_reg <= 1'b0;
      timeOutFlag_reg <= 1'b1;
      powerDownFlag_reg <= 1'b1;
      watchdogCounter_reg <= 8'h00;
      postscaler_reg <= 8'h00;
      idxBase_reg <= sub_sleep_pkg::IDXBASE_RST;
      memAddr_reg <= 12'h000;
      lastInstr_reg <= 16'h0000;
    end else begin
      dpWrite_reg <= dpWrite_next;
      rdWait_reg <= rdWait_next;
      dpAddr_reg <= dpAddr_next;
      hrdata_reg <= hrdata_next;
      wReg_reg <= wReg_next;
      status_reg <= status_next;
      bank_reg <= bank_next;
      extEn_reg <= extEn_next;
      asleep_reg <= asleep_next;
      timeOutFlag_reg <= timeOutFlag_next;
      powerDownFlag_reg <= powerDownFlag_next;
      watchdogCounter_reg <= watchdogCounter_next;
      postscaler_reg <= postscaler_next;
      idxBase_reg <= idxBase_next;
      memAddr_reg <= memAddr_next;
      lastInstr_reg <= lastInstr_next;
    end
  end
  // Data space storage, no reset
  always_ff @(posedge clk) begin
    if (memWe) begin
      mem[memWa] <= memWd;
    end
  end

  // Sequences for the checks
  sequence s_sleep_exec;
    instrWr && (op == sub_sleep_pkg::OP_SLEEP);
  endsequence
  sequence s_file_exec;
    isFile;
  endsequence

  a_sleep_flags: assert property (@(posedge clk) disable iff (!rstSync2_reg)
    s_sleep_exec |=> timeOutFlag_reg && !powerDownFlag_reg)
    else $error("sleep did not set status flags");
  a_sleep_wdog: assert property (@(posedge clk) disable iff (!rstSync2_reg)
    s_sleep_exec |=> (watchdogCounter_reg == 8'h00) && (postscaler_reg == 8'h00))
    else $error("sleep did not clear watchdog");
  a_sleep_halt: assert property (@(posedge clk) disable iff (!rstSync2_reg)
    s_sleep_exec |=> oscStopped [*2])
    else $error("oscillator not halted after sleep");
  a_lit_sub: assert property (@(posedge clk) disable iff (!rstSync2_reg)
    isLit |=> wReg_reg == 8'($past(op[7:0]) - $past(wReg_reg)))
    else $error("literal subtract result wrong");
  a_file_sub: assert property (@(posedge clk) disable iff (!rstSync2_reg)
    (isFile && (op[15:10] == sub_sleep_pkg::OP_FILE_SUB) && !op[9])
    |=> wReg_reg == 8'($past(fileVal) - $past(wReg_reg)))
    else $error("file subtract result wrong");
  a_file_subb: assert property (@(posedge clk) disable iff (!rstSync2_reg)
    (isFile && (op[15:10] == sub_sleep_pkg::OP_FILE_SUBB) && !op[9])
    |=> wReg_reg == 8'($past(fileVal) - $past(wReg_reg) - 8'(!$past(status_reg[0]))))
    else $error("file subtract with borrow wrong");
  a_work_subb: assert property (@(posedge clk) disable iff (!rstSync2_reg)
    (isFile && (op[15:10] == sub_sleep_pkg::OP_WORK_SUBB) && !op[9])
    |=> wReg_reg == 8'($past(wReg_reg) - $past(fileVal) - 8'(!$past(status_reg[0]))))
    else $error("working minus file wrong");
  a_dest_file: assert property (@(posedge clk) disable iff (!rstSync2_reg)
    (s_file_exec ##0 op[9]) |=> $stable(wReg_reg) && (mem[$past(fileAddr)] == $past(alu.result)))
    else $error("file destination not written");
  a_bank_pick: assert property (@(posedge clk) disable iff (!rstSync2_reg)
    (isFile && op[8]) |-> fileAddr[11:8] == bank_reg)
    else $error("bank select not used");
  a_indexed: assert property (@(posedge clk) disable iff (!rstSync2_reg)
    (isFile && !op[8] && extEn_reg && (op[7:0] <= sub_sleep_pkg::INDEXED_LIMIT))
    |-> fileAddr == 12'(idxBase_reg + {4'h0, op[7:0]}))
    else $error("indexed offset address wrong");
  a_carry_flag: assert property (@(posedge clk) disable iff (!rstSync2_reg)
    isLit |=> status_reg[0] == ($past(op[7:0]) >= $past(wReg_reg)))
    else $error("carry not set on no borrow");
endmodule
`default_nettype wire

// ### dv/subtract_and_sleep_ops_test.sv
// Self-checking bench for the subtract and low-power execution block.
// Assumes the block is the only AHB-Lite slave and its hreadyout is the bus ready.
`timescale 1ns/1ps
`default_nettype none
module subtract_and_sleep_ops_test;
  logic        clk;        // 250 MHz bus clock
  logic        rstN;       // Active low reset
  logic        hsel;       // Slave select
  logic [31:0] haddr;      // Byte address
  logic [1:0]  htrans;     // Transfer type
  logic        hwrite;     // Write strobe
  logic [31:0] hwdata;     // Write data
  logic        hreadyout;  // Slave ready, fed back as bus ready
  logic        hresp;      // Response, always OKAY
  logic [31:0] hrdata;     // Read data
  logic        oscStopped; // Low-power indicator
  int          errTotal;   // Mismatches seen
  int          checksDone; // Comparisons made
  logic [31:0] rdv;        // Last read word
  logic [12:0] r;          // Reference flags and result
  logic [7:0]  litW [4] = '{8'h01, 8'h02, 8'h03, 8'hFF};  // Working values
  logic [7:0]  litK [4] = '{8'h02, 8'h02, 8'h02, 8'h7F};  // Literals
  logic [7:0]  fVal [4] = '{8'h03, 8'h1B, 8'h02, 8'h80};  // File values
  logic [7:0]  wVal [4] = '{8'h02, 8'h1A, 8'h05, 8'h01};  // Working values
  logic [5:0]  fOps [3] = '{sub_sleep_pkg::OP_FILE_SUB, sub_sleep_pkg::OP_FILE_SUBB, sub_sleep_pkg::OP_WORK_SUBB};

  sub_sleep_core DUT (
    .clk(clk), .rst_n(rstN), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .oscStopped(oscStopped)
  );

  // Free-running clock
  always #2 clk = ~clk;

  // Counts and reports one compared word
  task automatic cmp(input string name, input logic [31:0] exp, input logic [31:0] got);
    checksDone++;
    if (got !== exp) begin
      errTotal++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  // One single word transfer; waits on ready, never on a fixed latency
  task automatic bus(input logic wr, input logic [7:0] ofs, input logic [31:0] wd, output logic [31:0] rd);
    logic rdy;
    logic rsp;
    int   n;
    hsel   <= 1'b1;
    haddr  <= {24'h00_0000, ofs};
    htrans <= 2'b10;
    hwrite <= wr;
    n = 0;
    do begin
      @(negedge clk);
      rdy = hreadyout;
      @(posedge clk);
      n++;
    end while (rdy !== 1'b1 && n < 50);
    htrans <= 2'b00;
    hwdata <= wd;
    do begin
      @(negedge clk);
      rdy = hreadyout;
      rd  = hrdata;
      rsp = hresp;
      @(posedge clk);
      n++;
    end while (rdy !== 1'b1 && n < 100);
    cmp("bus ready", 32'h0000_0001, 32'(rdy));
    cmp("bus response", 32'h0000_0000, 32'(rsp));
  endtask

  // Register write
  task automatic wr(input logic [7:0] ofs, input logic [31:0] wd);
    logic [31:0] unused;
    bus(1'b1, ofs, wd, unused);
  endtask

  // Register read and compare
  task automatic regChk(input string name, input logic [7:0] ofs, input logic [31:0] exp);
    bus(1'b0, ofs, 32'h0000_0000, rdv);
    cmp(name, exp, rdv);
  endtask

  // Data memory byte access through the address and data window
  task automatic memPut(input logic [11:0] a, input logic [7:0] v);
    wr(sub_sleep_pkg::OFS_MEMADDR, 32'(a));
    wr(sub_sleep_pkg::OFS_MEMDATA, 32'(v));
  endtask

  // Independent subtract model: {N, OV, Z, DC, C, result}, carry high means no borrow
  function automatic logic [12:0] subRef(input logic [7:0] a, input logic [7:0] b, input logic cin);
    logic [8:0] s;
    logic [4:0] lo;
    s  = {1'b0, a} + {1'b0, ~b} + 9'(cin);
    lo = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + 5'(cin);
    return {s[7], (a[7] != b[7]) && (s[7] != a[7]), s[7:0] == 8'h00, lo[4], s[8], s[7:0]};
  endfunction

  // One file-operand subtract, checking working register, file byte and flags
  task automatic fileOp(input logic [5:0] op, input logic d, input logic a, input logic [7:0] f,
                        input logic [11:0] addr, input logic [7:0] fv, input logic [7:0] wv, input logic cin);
    logic [12:0] e;
    memPut(addr, fv);
    wr(sub_sleep_pkg::OFS_WORKING, 32'(wv));
    wr(sub_sleep_pkg::OFS_STATUS, 32'(cin));
    wr(sub_sleep_pkg::OFS_INSTR, {16'h0000, op, d, a, f});
    if (op == sub_sleep_pkg::OP_WORK_SUBB) e = subRef(wv, fv, cin);
    else if (op == sub_sleep_pkg::OP_FILE_SUB) e = subRef(fv, wv, 1'b1);
    else e = subRef(fv, wv, cin);
    regChk("working register", sub_sleep_pkg::OFS_WORKING, 32'(d ? wv : e[7:0]));
    wr(sub_sleep_pkg::OFS_MEMADDR, 32'(addr));
    regChk("file byte", sub_sleep_pkg::OFS_MEMDATA, 32'(d ? e[7:0] : fv));
    regChk("status flags", sub_sleep_pkg::OFS_STATUS, 32'(e[12:8]));
  endtask

  // Verdict and end of run
  task automatic stopTest;
    if (errTotal == 0 && checksDone > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Cuts a hang short well beyond the expected run length
  initial begin
    #200000;
    errTotal++;
    stopTest();
  end

  // Main sequence
  initial begin
    clk = 1'b0; rstN = 1'b0; hsel = 1'b0; haddr = 32'h0000_0000; htrans = 2'b00;
    hwrite = 1'b0; hwdata = 32'h0000_0000; errTotal = 0; checksDone = 0;
    repeat (12) @(posedge clk);
    rstN <= 1'b1;
    repeat (3) @(posedge clk);
    // Reset state and an unmapped offset
    regChk("power flags", sub_sleep_pkg::OFS_POWER, 32'h0000_0003);
    regChk("status flags", sub_sleep_pkg::OFS_STATUS, 32'h0000_0000);
    regChk("unmapped word", 8'h40, 32'h0000_0000);
    // Literal minus working; stale borrow must not leak in
    foreach (litW[i]) begin
      r = subRef(litK[i], litW[i], 1'b1);
      wr(sub_sleep_pkg::OFS_STATUS, 32'h0000_0000);
      wr(sub_sleep_pkg::OFS_WORKING, 32'(litW[i]));
      wr(sub_sleep_pkg::OFS_INSTR, {16'h0000, sub_sleep_pkg::OP_LIT_SUB, litK[i]});
      regChk("working register", sub_sleep_pkg::OFS_WORKING, 32'(r[7:0]));
      regChk("status flags", sub_sleep_pkg::OFS_STATUS, 32'(r[12:8]));
    end
    // All file-operand variants, both destinations, both carry values
    wr(sub_sleep_pkg::OFS_BANKSEL, 32'h0000_0003);
    for (int k = 0; k < 12; k++) begin
      fileOp(fOps[k / 4], k[1], 1'b1, 8'h45, 12'h345, fVal[k % 4], wVal[k % 4], k[0]);
    end
    // Access bank halves against bank select
    wr(sub_sleep_pkg::OFS_BANKSEL, 32'h0000_0005);
    wr(sub_sleep_pkg::OFS_IDXBASE, 32'h0000_0200);
    fileOp(sub_sleep_pkg::OP_FILE_SUB, 1'b1, 1'b0, 8'h20, 12'h020, 8'h10, 8'h01, 1'b1);
    fileOp(sub_sleep_pkg::OP_FILE_SUB, 1'b1, 1'b0, 8'hA0, 12'hFA0, 8'h11, 8'h02, 1'b1);
    fileOp(sub_sleep_pkg::OP_FILE_SUB, 1'b1, 1'b1, 8'h20, 12'h520, 8'h12, 8'h03, 1'b1);
    // Indexed window edge with the extended set on
    wr(sub_sleep_pkg::OFS_CTRL, 32'h0000_0001);
    fileOp(sub_sleep_pkg::OP_FILE_SUBB, 1'b1, 1'b0, 8'h5F, 12'h25F, 8'h40, 8'h04, 1'b0);
    fileOp(sub_sleep_pkg::OP_WORK_SUBB, 1'b1, 1'b0, 8'h60, 12'hF60, 8'h41, 8'h05, 1'b1);
    fileOp(sub_sleep_pkg::OP_FILE_SUB, 1'b0, 1'b1, 8'h20, 12'h520, 8'h42, 8'h06, 1'b1);
    // Near-miss encoding must not sleep
    wr(sub_sleep_pkg::OFS_INSTR, 32'h0000_0103);
    @(negedge clk);
    cmp("oscillator stopped", 32'h0000_0000, 32'(oscStopped));
    @(posedge clk);
    // Let the watchdog postscaler advance, then sleep
    repeat (600) @(posedge clk);
    bus(1'b0, sub_sleep_pkg::OFS_WATCHDOG, 32'h0000_0000, rdv);
    cmp("watchdog running", 32'h0000_0001, 32'(rdv[15:8] != 8'h00));
    wr(sub_sleep_pkg::OFS_INSTR, 32'(sub_sleep_pkg::OP_SLEEP));
    bus(1'b0, sub_sleep_pkg::OFS_WATCHDOG, 32'h0000_0000, rdv);
    cmp("watchdog cleared", 32'h0000_0001, 32'(rdv[15:8] == 8'h00 && rdv[7:0] <= 8'h08));
    regChk("power flags", sub_sleep_pkg::OFS_POWER, 32'h0000_0006);
    cmp("oscillator stopped", 32'h0000_0001, 32'(oscStopped));
    // Instructions are held off while asleep, then wake
    wr(sub_sleep_pkg::OFS_WORKING, 32'h0000_0001);
    wr(sub_sleep_pkg::OFS_INSTR, 32'h0000_0809);
    regChk("working register", sub_sleep_pkg::OFS_WORKING, 32'h0000_0001);
    wr(sub_sleep_pkg::OFS_CTRL, 32'h0000_0002);
    @(negedge clk);
    cmp("oscillator stopped", 32'h0000_0000, 32'(oscStopped));
    @(posedge clk);
    regChk("power flags", sub_sleep_pkg::OFS_POWER, 32'h0000_0002);
    stopTest();
  end
endmodule
`default_nettype wire
